// [logic/sgcaf_front_end.sv]
// sgcaf_front_end: command/address capture, bank tracking, power states.
// Assumes caPins comes from pins clocked by ckIn; data side on dclkLo and dclkHi.
`timescale 1ns/1ps
module sgcaf_front_end (
	input wire logic clk, // command clock, rising edge
	input wire logic rst, // async reset, active high
	input wire logic ce, // clock enable, freezes command-clock state while low
	input wire logic dclkLo, // low lane data clock
	input wire logic dclkHi, // high lane data clock
	input wire sgcafe_pkg::sgcaf_ca_s caPins, // command/address pins
	input wire logic clockEnableN, // clock enable pin, active low
	input wire logic widthStrap, // 1 = x16 at init
	input wire logic [sgcafe_pkg::CORE_W-1:0] rdCore, // core read word
	input wire logic [sgcafe_pkg::WORD_W-1:0] wrPins, // data lines in
	output sgcafe_pkg::sgcaf_req_s reqOut, // decoded command
	output sgcafe_pkg::sgcaf_acc_s accOut, // read/write access
	output logic [sgcafe_pkg::NUM_BANKS-1:0] bankOpen, // per bank open row
	output logic [sgcafe_pkg::NUM_BANKS*sgcafe_pkg::ADDR_W-1:0] rowAddr, // open rows
	output logic [sgcafe_pkg::BANK_W-1:0] modeRegSel, // mode register selected
	output logic [sgcafe_pkg::ADDR_W-1:0] modeOpcode, // mode register opcode
	output logic modeWrite, // mode write pulse
	output logic [sgcafe_pkg::ADDR_W-1:0] preloadData, // fifo preload data
	output logic fifoPreloadCmd, // fifo preload pulse
	output sgcafe_pkg::sgcaf_pwr_e pwrState, // power state
	output logic cmdRxEn, // command/address receivers on
	output logic dclkRxEn, // data clock receivers on
	output logic termSel, // command termination select
	output logic termEn, // terminations enabled
	output logic x16Mode, // detected width
	output logic [sgcafe_pkg::WORD_W-1:0] rdPins, // data lines out
	output logic [sgcafe_pkg::WORD_W/sgcafe_pkg::LANE_HALF-1:0] rdOe, // per pair enable
	output logic [sgcafe_pkg::CORE_W-1:0] wrCore, // write word to core
	output logic wrCoreValid // write word ready pulse
);
	import sgcafe_pkg::*;

	sgcaf_ca_s s1_q;
	sgcaf_ca_s s2_q;
	logic [ADDR_W-1:0] lowAddr_q;
	logic ckeS1_q;
	logic ckeS2_q;
	logic [1:0] initStep_q;
	logic [1:0] strapS_q;
	logic [1:0] doneLo_q;
	logic [1:0] doneHi_q;
	logic wrPend_q;
	logic [NUM_BANKS-1:0] open_d;
	logic startTgl_q;
	logic isWr_q;
	logic doneTglLo;
	logic doneTglHi;
	logic rdOeLo;
	logic rdOeHi;
	logic [WORD_W-1:0] rdLo;
	logic [WORD_W-1:0] rdHi;
	logic [CORE_W-1:0] wrLo;
	logic [CORE_W-1:0] wrHi;
	logic [WORD_W-1:0] rdPinsRaw;
	logic [CORE_W-1:0] wrCoreRaw;
	logic [1:0] rdOeRaw;
	sgcaf_cmd_e cmd;
	logic [ADDR_W-1:0] fullAddr;
	logic [COL_W-1:0] colMask;

	function automatic sgcaf_cmd_e decodeCmd(input sgcaf_ca_s ca);
		if (ca.csN)
			return SGCAF_CMD_NOP;
		return sgcaf_cmd_e'({1'b0, ca.rasN, ca.casN, ca.weN});
	endfunction : decodeCmd

	// inverted-edge capture of the address bus; only bits 7:0 are used
	always_ff @(negedge clk or posedge rst) begin
		if (rst)
			lowAddr_q <= '0;
		else if (ce)
			lowAddr_q <= caPins.addrBus;
	end

	// two flops on every pin before decode; rising edge, except address bits 7:0, which are first taken on the inverted edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, default: '0};
			s2_q <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, default: '0};
			ckeS1_q <= 1'b0;
			ckeS2_q <= 1'b0;
			strapS_q <= '0;
		end else if (ce) begin
			s1_q <= caPins;
			s2_q <= s1_q;
			// bits 7:0 come from the inverted edge after the command edge
			s2_q.addrBus[7:0] <= lowAddr_q[7:0];
			strapS_q <= {strapS_q[0], widthStrap};
			ckeS1_q <= clockEnableN;
			ckeS2_q <= ckeS1_q;
		end
	end

	assign cmd = (pwrState == SGCAF_PWR_ON) ? decodeCmd(s2_q) : SGCAF_CMD_NOP;
	assign fullAddr = s2_q.addrBus;
	assign colMask = x16Mode ? {COL_W{1'b1}} : COL_W'({COL_NARROW_W{1'b1}});

	// strap catch at reset release, held afterwards
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			initStep_q <= 2'h0;
			termSel <= 1'b0;
			x16Mode <= 1'b0;
			termEn <= 1'b0;
		end else if (ce) begin
			termEn <= 1'b1;
			if (initStep_q != 2'h3)
				initStep_q <= initStep_q + 2'h1;
			// synchronisers hold post-release samples from the third edge on
			if (initStep_q == 2'h2) begin
				termSel <= ckeS2_q;
				x16Mode <= strapS_q[1];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reqOut <= '{cmd: SGCAF_CMD_NOP, default: '0};
			accOut <= '0;
			modeWrite <= 1'b0;
			fifoPreloadCmd <= 1'b0;
			modeRegSel <= '0;
			modeOpcode <= '0;
			preloadData <= '0;
		end else if (ce) begin
			reqOut <= '{valid: cmd != SGCAF_CMD_NOP, cmd: cmd, bank: s2_q.bankSelect,
				addr: fullAddr};
			accOut.valid <= (cmd == SGCAF_CMD_RD) || (cmd == SGCAF_CMD_WR);
			accOut.write <= cmd == SGCAF_CMD_WR;
			accOut.autoPre <= fullAddr[AUTO_PRE_BIT];
			accOut.bank <= s2_q.bankSelect;
			accOut.column <= COL_W'(fullAddr) & colMask;
			modeWrite <= cmd == SGCAF_CMD_MRS;
			fifoPreloadCmd <= cmd == SGCAF_CMD_LDF;
			if (cmd == SGCAF_CMD_MRS) begin
				modeRegSel <= s2_q.bankSelect;
				modeOpcode <= fullAddr;
			end
			if (cmd == SGCAF_CMD_LDF)
				preloadData <= fullAddr;
		end
	end

	// per-bank open state and row
	always_comb begin
		open_d = bankOpen;
		if (cmd == SGCAF_CMD_ACT)
			open_d[s2_q.bankSelect] = 1'b1;
		if (cmd == SGCAF_CMD_PRE) begin
			if (fullAddr[ALL_BANK_BIT])
				open_d = BANKS_IDLE;
			else
				open_d[s2_q.bankSelect] = 1'b0;
		end
		if (((cmd == SGCAF_CMD_RD) || (cmd == SGCAF_CMD_WR)) && fullAddr[AUTO_PRE_BIT])
			open_d[s2_q.bankSelect] = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bankOpen <= BANKS_IDLE;
			rowAddr <= '0;
		end else if (ce) begin
			bankOpen <= open_d;
			if (cmd == SGCAF_CMD_ACT)
				rowAddr[s2_q.bankSelect * ADDR_W +: ADDR_W] <= fullAddr;
		end
	end

	// power states from synchronised clock enable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwrState <= SGCAF_PWR_ON;
			cmdRxEn <= 1'b0;
			dclkRxEn <= 1'b0;
		end else if (ce) begin
			unique case (pwrState)
				SGCAF_PWR_ON: begin
					if (ckeS2_q) begin
						if (bankOpen != BANKS_IDLE)
							pwrState <= SGCAF_PWR_APD;
						else if (cmd == SGCAF_CMD_REF)
							pwrState <= SGCAF_PWR_SR;
						else
							pwrState <= SGCAF_PWR_PPD;
					end
				end
				SGCAF_PWR_APD, SGCAF_PWR_PPD: begin
					if (!ckeS2_q)
						pwrState <= SGCAF_PWR_ON;
				end
				SGCAF_PWR_SR: begin
					if (!ckeS2_q)
						pwrState <= SGCAF_PWR_ON;
				end
			endcase
			cmdRxEn <= pwrState == SGCAF_PWR_ON;
			dclkRxEn <= pwrState != SGCAF_PWR_SR;
		end
	end

	// burst launch toward both data clock pairs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			startTgl_q <= 1'b0;
			isWr_q <= 1'b0;
		end else if (ce && ((cmd == SGCAF_CMD_RD) || (cmd == SGCAF_CMD_WR))) begin
			startTgl_q <= ~startTgl_q;
			isWr_q <= cmd == SGCAF_CMD_WR;
		end
	end

	sgcaf_data_port uLo (
		.dclk(dclkLo),
		.rst(rst),
		.startTgl(startTgl_q),
		.isWrite(isWr_q),
		.rdCore(rdCore),
		.wrPins(wrPins),
		.rdPins(rdLo),
		.rdPinsOe(rdOeLo),
		.wrCore(wrLo),
		.doneTgl(doneTglLo)
	);

	sgcaf_data_port uHi (
		.dclk(dclkHi),
		.rst(rst),
		.startTgl(startTgl_q),
		.isWrite(isWr_q),
		.rdCore(rdCore),
		.wrPins(wrPins),
		.rdPins(rdHi),
		.rdPinsOe(rdOeHi),
		.wrCore(wrHi),
		.doneTgl(doneTglHi)
	);

	// lane split between the two pairs
	always_comb begin
		rdPinsRaw = {rdHi[WORD_W-1:LANE_HALF], rdLo[LANE_HALF-1:0]};
		rdOeRaw = {rdOeHi, rdOeLo};
		for (int i = 0; i < BURST_LEN; i++) begin
			wrCoreRaw[i*WORD_W +: WORD_W] = {wrHi[i*WORD_W+LANE_HALF +: LANE_HALF],
				wrLo[i*WORD_W +: LANE_HALF]};
		end
	end

	// pair outputs leave through data clock flops; crossing back on the done toggle
	always_ff @(posedge dclkLo or posedge rst) begin
		if (rst) begin
			rdPins <= '0;
			rdOe <= '0;
		end else begin
			rdPins <= rdPinsRaw;
			rdOe <= rdOeRaw;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			doneLo_q <= '0;
			doneHi_q <= '0;
			wrPend_q <= 1'b0;
			wrCore <= '0;
			wrCoreValid <= 1'b0;
		end else if (ce) begin
			// each done toggle synchronised on its own; latency in command cycles
			doneLo_q <= {doneLo_q[0], doneTglLo};
			doneHi_q <= {doneHi_q[0], doneTglHi};
			wrCoreValid <= 1'b0;
			if (cmd == SGCAF_CMD_WR)
				wrPend_q <= 1'b1;
			else if (wrPend_q && (doneLo_q[1] == startTgl_q) && (doneHi_q[1] == startTgl_q)) begin
				wrPend_q <= 1'b0;
				wrCoreValid <= 1'b1;
				wrCore <= wrCoreRaw;
			end
		end
	end
endmodule : sgcaf_front_end

// [logic/sgcafe_pkg.sv]
// sgcafe_pkg: constants, command codes, power states and carriers for the
// command/address front end. Assumes a single command-clock domain user side.
// Operation
// - commands are taken only on rising command clock edges
// - upper address and bank on rising edge, low address on next inverted edge
// - each access is a fixed burst of eight 32-bit words, 256 bits total
// - data moves on both data clock edges, two words per cycle; reads here drive only words 0, 2, 4 and 6, on rising edges
// - low data clock pair times lanes 0-15, high pair lanes 16-31; here read lanes 16-31 also leave on the low pair clock
// - activate takes row from all twelve address bits and bank select
// - read/write column from low bits, bit 8 asks auto precharge
// - row close: bit 8 low closes one bank, high closes all banks
// - bank select picks target bank, or mode register on mode write
// - address is opcode on mode write and data on fifo preload
// - chip select high masks commands, running operations still finish
// - command decoded from chip select, row, column strobes and write enable
// - clock enable high enters precharge/self-refresh power-down or active power-down
// - clock enable sampled synchronously for power-down entry, exit, self-refresh
// - power-down keeps clocks and clock enable receivers; self-refresh only clock enable
// - clock enable latched at reset release selects command termination value
// - width x32 or x16 detected at initialisation and kept afterwards
// - latencies are counted in command clock cycles
// - sixteen independent banks, each with its own open row
// - high chip reset resets all asynchronously and disables terminations
package sgcafe_pkg;
	localparam int NUM_BANKS = 16;
	localparam int BANK_W = 4;
	localparam int ADDR_W = 12;
	localparam int COL_W = 7;
	localparam int WORD_W = 32;
	localparam int BURST_LEN = 8;
	localparam int CORE_W = 256;
	localparam int BEAT_CNT_W = 3;
	localparam int AUTO_PRE_BIT = 8;
	localparam int ALL_BANK_BIT = 8;
	localparam int COL_NARROW_W = 6;
	localparam int LANE_HALF = 16;
	localparam int LAT_W = 5;
	localparam logic [15:0] BANKS_IDLE = 16'h0000;

	// {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SGCAF_CMD_MRS = 4'h0,
		SGCAF_CMD_REF = 4'h1,
		SGCAF_CMD_PRE = 4'h2,
		SGCAF_CMD_ACT = 4'h3,
		SGCAF_CMD_WR = 4'h4,
		SGCAF_CMD_RD = 4'h5,
		SGCAF_CMD_LDF = 4'h6,
		SGCAF_CMD_NOP = 4'h7
	} sgcaf_cmd_e;

	typedef enum logic [1:0] {
		SGCAF_PWR_ON = 2'b00,
		SGCAF_PWR_APD = 2'b01,
		SGCAF_PWR_PPD = 2'b11,
		SGCAF_PWR_SR = 2'b10
	} sgcaf_pwr_e;

	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [BANK_W-1:0] bankSelect;
		logic [ADDR_W-1:0] addrBus;
	} sgcaf_ca_s;

	typedef struct packed {
		logic valid;
		sgcaf_cmd_e cmd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
	} sgcaf_req_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic autoPre;
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0] column;
	} sgcaf_acc_s;
endpackage : sgcafe_pkg

// [logic/sgcaf_data_port.sv]
// sgcaf_data_port: data-clock side burst framing for one access.
// Assumes the data clock runs free; burst starts cross as a toggle.
`timescale 1ns/1ps
module sgcaf_data_port (
	input wire logic dclk, // forwarded data clock
	input wire logic rst, // async reset, active high
	input wire logic startTgl, // toggles once per access, command domain
	input wire logic isWrite, // stable with startTgl
	input wire logic [sgcafe_pkg::CORE_W-1:0] rdCore, // read core word
	input wire logic [sgcafe_pkg::WORD_W-1:0] wrPins, // write data at pins
	output logic [sgcafe_pkg::WORD_W-1:0] rdPins, // read data at pins
	output logic rdPinsOe, // read driver enable
	output logic [sgcafe_pkg::CORE_W-1:0] wrCore, // assembled write word
	output logic doneTgl // toggles when burst ends
);
	import sgcafe_pkg::*;
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic busy_q;
	logic wr_q;
	logic tail_q;
	logic [BEAT_CNT_W-1:0] beat_q;
	logic [WORD_W-1:0] rdNeg_q;
	logic [WORD_W-1:0] wrNeg_q;

	always_ff @(posedge dclk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= startTgl;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// beats step two per data clock cycle, one on each edge
	always_ff @(posedge dclk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			wr_q <= 1'b0;
			beat_q <= '0;
			tail_q <= 1'b0;
			doneTgl <= 1'b0;
		end else begin
			tail_q <= 1'b0;
			// done only after the last falling-edge word has landed
			if (tail_q)
				doneTgl <= ~doneTgl;
			if (!busy_q && (s2_q != s3_q)) begin
				busy_q <= 1'b1;
				wr_q <= isWrite;
				beat_q <= '0;
			end else if (busy_q) begin
				beat_q <= beat_q + BEAT_CNT_W'(2);
				if (beat_q == BEAT_CNT_W'(BURST_LEN - 2)) begin
					busy_q <= 1'b0;
					tail_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(negedge dclk or posedge rst) begin
		if (rst) begin
			rdNeg_q <= '0;
			wrNeg_q <= '0;
		end else begin
			rdNeg_q <= rdCore[(32'(beat_q) + 1) * WORD_W +: WORD_W];
			wrNeg_q <= wrPins;
		end
	end

	always_ff @(posedge dclk or posedge rst) begin
		if (rst) begin
			rdPins <= '0;
			rdPinsOe <= 1'b0;
			wrCore <= '0;
		end else begin
			rdPinsOe <= busy_q && !wr_q;
			rdPins <= busy_q ? rdCore[32'(beat_q) * WORD_W +: WORD_W] : rdNeg_q;
			if (busy_q && wr_q) begin
				wrCore[32'(beat_q) * WORD_W +: WORD_W] <= wrPins;
				if (beat_q != '0)
					wrCore[(32'(beat_q) - 1) * WORD_W +: WORD_W] <= wrNeg_q;
			end else if (wr_q && tail_q) begin
				wrCore[(BURST_LEN - 1) * WORD_W +: WORD_W] <= wrNeg_q;
			end
		end
	end
endmodule : sgcaf_data_port

// [verif/sgcaf_front_end_properties.sv]
// checker: port properties of the command/address front end.
// Assumes it is bound into sgcaf_front_end and sees only its ports.
`timescale 1ns/1ps
module sgcaf_front_end_checker
	import sgcafe_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic ce, // enable
	input wire sgcafe_pkg::sgcaf_ca_s caPins, // pins
	input wire logic clockEnableN, // cke pin
	input wire sgcafe_pkg::sgcaf_req_s reqOut, // command
	input wire sgcafe_pkg::sgcaf_acc_s accOut, // access
	input wire logic [sgcafe_pkg::NUM_BANKS-1:0] bankOpen, // banks
	input wire sgcafe_pkg::sgcaf_pwr_e pwrState, // power
	input wire logic cmdRxEn, // cmd rx
	input wire logic dclkRxEn, // dclk rx
	input wire logic termSel, // term value
	input wire logic termEn, // term on
	input wire logic x16Mode // width
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	a_cs_masks: assert property (caPins.csN[*4] |=> !accOut.valid
		&& !(reqOut.valid && reqOut.cmd != SGCAF_CMD_NOP))
		else $error("command taken while deselected");
	a_cmd_decode: assert property (reqOut.valid && reqOut.cmd != SGCAF_CMD_NOP |->
		($past(caPins[19:16], 3) == reqOut.cmd && $past(caPins.bankSelect, 3) == reqOut.bank)
		|| ($past(caPins[19:16], 4) == reqOut.cmd && $past(caPins.bankSelect, 4) == reqOut.bank))
		else $error("decoded command differs from pins");
	a_act_opens: assert property (reqOut.valid && reqOut.cmd == SGCAF_CMD_ACT
		|=> bankOpen[$past(reqOut.bank)])
		else $error("activated bank not open");
	a_close_all: assert property (reqOut.valid && reqOut.cmd == SGCAF_CMD_PRE
		&& reqOut.addr[ALL_BANK_BIT] |=> bankOpen == BANKS_IDLE)
		else $error("close all left a bank open");
	a_ppd_idle: assert property (pwrState == SGCAF_PWR_PPD |-> bankOpen == BANKS_IDLE)
		else $error("precharge power down with open bank");
	a_apd_open: assert property (pwrState == SGCAF_PWR_APD |-> bankOpen != BANKS_IDLE)
		else $error("active power down with all banks idle");
	a_sr_rx_off: assert property (pwrState == SGCAF_PWR_SR
		&& $past(pwrState) == SGCAF_PWR_SR |-> !cmdRxEn && !dclkRxEn)
		else $error("receiver on in self refresh");
	a_pd_rx_keep: assert property ($stable(pwrState)
		&& pwrState inside {SGCAF_PWR_APD, SGCAF_PWR_PPD} |-> !cmdRxEn && dclkRxEn)
		else $error("wrong receivers in power down");
	a_pd_entry: assert property ((clockEnableN && ce)[*8] |-> pwrState != SGCAF_PWR_ON)
		else $error("no power down with clock enable high");
	a_width_kept: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
		&& !$past(rst, 4) |->
		$stable(x16Mode) && $stable(termSel) && termEn)
		else $error("width or termination changed after init");
	a_term_reset: assert property (disable iff (1'b0) rst |-> !termEn)
		else $error("termination on during reset");
endmodule : sgcaf_front_end_checker

// [verif/sgcaf_ctrl_model.sv]
// controller model: free data clocks and a changing write word on the lanes.
// Assumes nothing; starts at time zero with an odd phase offset.
`timescale 1ns/1ps
module sgcaf_ctrl_model (
	output logic dclkLo, // low pair clock
	output logic dclkHi, // high pair clock
	output logic [sgcafe_pkg::WORD_W-1:0] wrPins // write lanes
);
	initial begin
		dclkLo = 1'b0;
		dclkHi = 1'b0;
		wrPins = 32'h0;
		#3.3;
		forever begin
			#40;
			wrPins = wrPins + 32'h01010101;
			#40;
			dclkLo = ~dclkLo;
			dclkHi = ~dclkHi;
		end
	end
endmodule : sgcaf_ctrl_model

// [verif/sgcaf_front_end_test.sv]
// bench: drives command, power and reset pins and checks the outputs except read lanes and enables, write word and mode/preload pulses.
// Assumes the controller model makes data clocks and write lanes.
`timescale 1ns/1ps
module sgcaf_front_end_test;
	import sgcafe_pkg::*;
	logic clk, rst, ce, clockEnableN, widthStrap, dclkLo, dclkHi, termSel, termEn, x16Mode;
	logic cmdRxEn, dclkRxEn, wrCoreValid, xMode;
	logic [WORD_W-1:0] wrPins;
	logic [CORE_W-1:0] rdCore;
	logic [NUM_BANKS-1:0] bankOpen;
	logic [NUM_BANKS*ADDR_W-1:0] rowAddr;
	logic [BANK_W-1:0] modeRegSel;
	logic [ADDR_W-1:0] modeOpcode, preloadData, rows [NUM_BANKS];
	sgcaf_ca_s caPins;
	sgcaf_req_s reqOut, expQ[$];
	sgcaf_acc_s accOut, accQ[$];
	sgcaf_pwr_e pwrState;
	int errorCnt = 0, totalChecks = 0, n, cycleCnt = 0;
	sgcaf_front_end u_dut (.clk(clk), .rst(rst), .ce(ce), .dclkLo(dclkLo), .dclkHi(dclkHi),
		.caPins(caPins), .clockEnableN(clockEnableN), .widthStrap(widthStrap), .rdCore(rdCore),
		.wrPins(wrPins), .reqOut(reqOut), .accOut(accOut), .bankOpen(bankOpen),
		.rowAddr(rowAddr), .modeRegSel(modeRegSel), .modeOpcode(modeOpcode), .modeWrite(),
		.preloadData(preloadData), .fifoPreloadCmd(), .pwrState(pwrState), .cmdRxEn(cmdRxEn),
		.dclkRxEn(dclkRxEn), .termSel(termSel), .termEn(termEn), .x16Mode(x16Mode),
		.rdPins(), .rdOe(), .wrCore(), .wrCoreValid(wrCoreValid));
	sgcaf_ctrl_model u_ctrl (.dclkLo(dclkLo), .dclkHi(dclkHi), .wrPins(wrPins));
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic testDone;
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : testDone
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask : settle
	// low address stays one more cycle for the inverted-edge sample
	task automatic issue(input logic [3:0] c, input logic [3:0] b, input logic [11:0] a,
		input logic take, input logic cke);
		@(posedge clk);
		caPins <= {c, b, a};
		clockEnableN <= cke;
		if (take && c != 4'h7 && !c[3])
			expQ.push_back('{1'b1, sgcaf_cmd_e'(c), b, a});
		if (take && c[3:1] == 3'h2)
			accQ.push_back('{1'b1, !c[0], a[AUTO_PRE_BIT], b, 7'(a) & (xMode ? 7'h7f : 7'h3f)});
		@(posedge clk);
		caPins <= {c[3], 3'h7, b, a};
		@(posedge clk);
		caPins <= {c[3], 3'h7, ~b, ~a};
		repeat (3) @(posedge clk);
	endtask : issue
	task automatic doReset(input logic cke, input logic w);
		@(posedge clk);
		rst <= 1'b1;
		clockEnableN <= cke;
		widthStrap <= w;
		xMode = w;
		repeat (3) @(posedge dclkLo);
		@(posedge clk);
		chk("term in reset", 24'h0, 24'(termEn));
		rst <= 1'b0;
		@(posedge clk);
		clockEnableN <= 1'b0;
		settle(3);
		chk("term select", 24'(cke), 24'(termSel));
		chk("width", 24'(w), 24'(x16Mode));
		chk("term on", 24'h1, 24'(termEn));
	endtask : doReset
	always @(negedge clk) begin
		if (!rst && reqOut.valid === 1'b1 && reqOut.cmd !== SGCAF_CMD_NOP) begin
			if (expQ.size() > 0)
				chk("command", 24'(expQ.pop_front()), 24'(reqOut));
			else
				chk("masked command", 24'h0, 24'(reqOut));
		end
		if (!rst && accOut.valid === 1'b1) begin
			if (accQ.size() > 0)
				chk("access", 24'(accQ.pop_front()), 24'(accOut));
			else
				chk("extra access", 24'h0, 24'(accOut));
		end
	end
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		while (cycleCnt < 6000) begin
			@(posedge clk);
			cycleCnt++;
		end
		errorCnt++;
		$display("wrong value run length expected end seen hang");
		testDone();
	end
	initial begin
		void'($urandom(32'ha61e));
		ce <= 1'b1;
		rst <= 1'b1;
		caPins <= {4'h7, 16'h0};
		for (int i = 0; i < 8; i++)
			rdCore[i*32 +: 32] <= $urandom;
		doReset(1'b0, 1'b0);
		for (int i = 0; i < NUM_BANKS; i++) begin
			rows[i] = 12'($urandom);
			issue(4'h3, 4'(i), rows[i], 1'b1, 1'b0);
		end
		settle(4);
		chk("open banks", 24'hffff, 24'(bankOpen));
		for (int i = 0; i < NUM_BANKS; i++)
			chk("row", 24'(rows[i]), 24'(rowAddr[i*ADDR_W +: ADDR_W]));
		issue(4'h5, 4'h2, 12'($urandom) & 12'heff, 1'b1, 1'b0);
		settle(200);
		issue(4'h4, 4'h3, 12'($urandom) | 12'h100, 1'b1, 1'b0);
		n = 0;
		while (wrCoreValid !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("write burst", 24'h1, 24'(wrCoreValid));
		settle(40);
		chk("auto precharge", 24'hfff7, 24'(bankOpen));
		issue(4'h2, 4'h5, 12'h0, 1'b1, 1'b0);
		settle(2);
		chk("close one", 24'hffd7, 24'(bankOpen));
		issue(4'h2, 4'h0, 12'h100, 1'b1, 1'b0);
		settle(2);
		chk("close all", 24'h0, 24'(bankOpen));
		$display("test banks done");
		issue(4'h0, 4'ha, 12'h5c3, 1'b1, 1'b0);
		settle(2);
		chk("mode select", 24'ha, 24'(modeRegSel));
		chk("mode opcode", 24'h5c3, 24'(modeOpcode));
		issue(4'h6, 4'h0, 12'h3a6, 1'b1, 1'b0);
		issue(4'h1, 4'h0, 12'h0, 1'b1, 1'b0);
		settle(2);
		chk("preload", 24'h3a6, 24'(preloadData));
		for (int c = 8; c < 16; c++)
			issue(4'(c), 4'($urandom), 12'($urandom), 1'b0, 1'b0);
		settle(4);
		chk("masked", 24'h0, 24'(bankOpen));
		$display("test commands done");
		@(posedge clk);
		clockEnableN <= 1'b1;
		settle(12);
		chk("precharge power down", 24'(SGCAF_PWR_PPD), 24'(pwrState));
		chk("receivers", 24'h1, 24'({cmdRxEn, dclkRxEn}));
		issue(4'h3, 4'h1, 12'h0, 1'b0, 1'b1);
		clockEnableN <= 1'b0;
		settle(12);
		chk("ignored in power down", 24'h0, 24'(bankOpen));
		issue(4'h3, 4'h9, 12'h0, 1'b1, 1'b0);
		clockEnableN <= 1'b1;
		settle(12);
		chk("active power down", 24'(SGCAF_PWR_APD), 24'(pwrState));
		@(posedge clk);
		clockEnableN <= 1'b0;
		settle(12);
		issue(4'h2, 4'h0, 12'h100, 1'b1, 1'b0);
		issue(4'h1, 4'h0, 12'h0, 1'b1, 1'b1);
		settle(12);
		chk("self refresh", 24'(SGCAF_PWR_SR), 24'(pwrState));
		chk("receivers off", 24'h0, 24'({cmdRxEn, dclkRxEn}));
		@(posedge clk);
		clockEnableN <= 1'b0;
		settle(20);
		chk("awake", 24'(SGCAF_PWR_ON), 24'(pwrState));
		$display("test power done");
		doReset(1'b1, 1'b1);
		issue(4'h3, 4'h0, 12'h7ff, 1'b1, 1'b0);
		issue(4'h5, 4'h0, 12'($urandom) | 12'h040, 1'b1, 1'b0);
		settle(40);
		chk("pending", 24'h0, 24'(expQ.size() + accQ.size()));
		$display("test narrow width done");
		testDone();
	end
endmodule : sgcaf_front_end_test
bind sgcaf_front_end sgcaf_front_end_checker u_chk (.clk(clk), .rst(rst), .ce(ce),
	.caPins(caPins), .clockEnableN(clockEnableN), .reqOut(reqOut), .accOut(accOut),
	.bankOpen(bankOpen), .pwrState(pwrState), .cmdRxEn(cmdRxEn), .dclkRxEn(dclkRxEn),
	.termSel(termSel), .termEn(termEn), .x16Mode(x16Mode));
